// ==== common/otg_ctrl_pkg.sv ====
// Purpose: shared constants for the otg port control block
// Assumes: register reached by read/write command codes
// Notes:   bit positions and reset values of the control word
`default_nettype none
package otg_ctrl_pkg;
  localparam int unsigned REG_W = 16;
  localparam logic [7:0] CMD_CTRL_RD = 8'h62;
  localparam logic [7:0] CMD_CTRL_WR = 8'hE2;
  localparam int unsigned BIT_RC_RESET  = 11;
  localparam int unsigned BIT_SRP_EN    = 10;
  localparam int unsigned BIT_SRP_SEL   = 9;
  localparam int unsigned BIT_ENG_SEL   = 8;
  localparam int unsigned BIT_DM_PD     = 7;
  localparam int unsigned BIT_DP_PD     = 6;
  localparam int unsigned BIT_AUTO_PU   = 5;
  localparam int unsigned BIT_LOC_PU    = 4;
  localparam logic [15:0] CTRL_RESET    = 16'h01c0;
  localparam logic [15:0] CTRL_WMASK    = 16'h0fff;
  localparam logic [15:0] ZERO16        = 16'h0000;
  // software-visible effect of the engine select bit
  typedef enum logic {ENG_HOST = 1'b0, ENG_PERIPH = 1'b1} engine_e;
endpackage
`default_nettype wire

// ==== src/otg_edge_sync.sv ====
// Purpose: two-flop synchroniser with rising edge pulse
// Assumes: input is asynchronous to mclk
// Notes:   first flop feeds only the second flop
`default_nettype none
module otg_edge_sync
(
  input  wire logic mclk,
  input  wire logic reset_n,
  input  wire logic async_in,
  output logic      level_out,
  output logic      rise_out
);
  logic meta_q;
  logic sync_q;
  logic last_q;

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end
    else
    begin
      meta_q <= async_in;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign level_out = sync_q;
  assign rise_out  = sync_q & ~last_q;
endmodule
`default_nettype wire

// ==== src/otg_port_control.sv ====
// Purpose: otg port control word and the port logic it steers
// Assumes: command strobes are on mclk; line events come from pins
// Notes:   srp flag set wins over its clear in the same cycle; se0 and auto pull-up latches clear first
//
// Operation
// - connect reset enable makes host send SE0
// - srp enable lets srp event set flag
// - method bit picks vbus or data pulsing
// - engine bit routes host or peripheral engine
// - dm pull-down follows its control bit
// - dp pull-down follows its control bit
// - auto bit raises pull-up on disconnect
// - auto bit clear: pull-up follows local bit
// - local bit connects dp pull-up
`default_nettype none
module otg_port_control
  import otg_ctrl_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              reset_n,
  input  wire logic              cmd_valid,
  input  wire logic [7:0]        cmd_code,
  input  wire logic [REG_W-1:0]  cmd_wdata,
  output logic      [REG_W-1:0]  cmd_rdata,
  input  wire logic              remote_connect_pin,
  input  wire logic              remote_disconnect_pin,
  input  wire logic              vbus_pulse_pin,
  input  wire logic              data_pulse_pin,
  input  wire logic              srp_flag_clear,
  output logic                   srp_detected_flag,
  output logic                   host_se0_reset,
  output logic                   host_engine_sel,
  output logic                   peripheral_engine_sel,
  output logic                   dm_pulldown_on,
  output logic                   dp_pulldown_on,
  output logic                   dp_pullup_on
);
  logic [REG_W-1:0] ctrl_q;
  logic [REG_W-1:0] ctrl_d;
  logic             srp_flag_q;
  logic             auto_pu_q;
  logic             se0_q;
  logic             pu_q;
  logic             rc_lvl;
  logic             rc_rise;
  logic             rd_rise;
  logic             vb_rise;
  logic             dl_rise;
  logic             srp_event;
  logic             wr_hit;
  // pin slots in the synchroniser bank
  localparam int unsigned PIN_N    = 4;
  localparam int unsigned PIN_CONN = 0;
  localparam int unsigned PIN_DISC = 1;
  localparam int unsigned PIN_VBUS = 2;
  localparam int unsigned PIN_DATA = 3;
  logic [PIN_N-1:0] pin_raw;
  logic [PIN_N-1:0] pin_lvl;
  logic [PIN_N-1:0] pin_rise;

  assign pin_raw[PIN_CONN] = remote_connect_pin;
  assign pin_raw[PIN_DISC] = remote_disconnect_pin;
  assign pin_raw[PIN_VBUS] = vbus_pulse_pin;
  assign pin_raw[PIN_DATA] = data_pulse_pin;

  // one synchroniser per line event pin; all pins idle low,
  // so the edge detectors start at the idle level
  for (genvar g = 0; g < PIN_N; g++)
  begin : g_pin_sync
    otg_edge_sync u_sync
    (
      .mclk      (mclk),
      .reset_n   (reset_n),
      .async_in  (pin_raw[g]),
      .level_out (pin_lvl[g]),
      .rise_out  (pin_rise[g])
    );
  end

  // only the connect level is used; other pins act on edges
  assign rc_lvl  = pin_lvl[PIN_CONN];
  assign rc_rise = pin_rise[PIN_CONN];
  assign rd_rise = pin_rise[PIN_DISC];
  assign vb_rise = pin_rise[PIN_VBUS];
  assign dl_rise = pin_rise[PIN_DATA];

  assign wr_hit = cmd_valid && (cmd_code == CMD_CTRL_WR);
  // reserved bits are masked off both ways
  assign ctrl_d = wr_hit ? (cmd_wdata & CTRL_WMASK) : ctrl_q;

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      ctrl_q <= CTRL_RESET;
    else
      ctrl_q <= ctrl_d;
  end

  // read data registered; unknown codes read zero
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      cmd_rdata <= ZERO16;
    else if (cmd_valid && (cmd_code == CMD_CTRL_RD))
      cmd_rdata <= ctrl_q & CTRL_WMASK;
    else if (cmd_valid)
      cmd_rdata <= ZERO16;
  end

  // only the selected pulsing method counts as srp
  assign srp_event = ctrl_q[BIT_SRP_SEL] ? dl_rise : vb_rise;

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      srp_flag_q <= 1'b0;
    else if (srp_event && ctrl_q[BIT_SRP_EN])
      srp_flag_q <= 1'b1;
    else if (srp_flag_clear)
      srp_flag_q <= 1'b0;
  end
  assign srp_detected_flag = srp_flag_q;

  // se0 held while connect is seen and enable stays set
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      se0_q <= 1'b0;
    else if (!ctrl_q[BIT_RC_RESET] || !rc_lvl)
      se0_q <= 1'b0;
    else if (rc_rise && !ctrl_q[BIT_ENG_SEL])
      se0_q <= 1'b1;
  end
  assign host_se0_reset = se0_q;

  // auto pull-up latch; dropped when software clears the bit
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      auto_pu_q <= 1'b0;
    else if (!ctrl_q[BIT_AUTO_PU])
      auto_pu_q <= 1'b0;
    else if (rd_rise)
      auto_pu_q <= 1'b1;
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      pu_q <= 1'b0;
    else
      pu_q <= ctrl_q[BIT_LOC_PU] | auto_pu_q;
  end
  assign dp_pullup_on = pu_q;

  assign host_engine_sel = (ctrl_q[BIT_ENG_SEL] == ENG_HOST);
  assign peripheral_engine_sel = (ctrl_q[BIT_ENG_SEL] == ENG_PERIPH);
  assign dm_pulldown_on        = ctrl_q[BIT_DM_PD];
  assign dp_pulldown_on        = ctrl_q[BIT_DP_PD];

  // srp detection
  srp_gate_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    !$past(srp_flag_q) && srp_flag_q |-> $past(ctrl_q[BIT_SRP_EN]))
    else $error("srp flag set while disabled");
  srp_off_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    !ctrl_q[BIT_SRP_EN] && !srp_flag_q |=> !srp_flag_q)
    else $error("srp flag set with detect off");
  srp_method_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    !$past(srp_flag_q) && srp_flag_q |->
      ($past(ctrl_q[BIT_SRP_SEL]) ? $past(dl_rise) : $past(vb_rise)))
    else $error("srp flag from wrong method");

  // bus reset on remote connect
  se0_enable_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    se0_q |-> $past(ctrl_q[BIT_RC_RESET]))
    else $error("se0 without enable");
  se0_start_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    rc_rise && ctrl_q[BIT_RC_RESET] && !ctrl_q[BIT_ENG_SEL] |=> se0_q)
    else $error("se0 not sent on connect");
  se0_off_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    !ctrl_q[BIT_RC_RESET] |=> !host_se0_reset)
    else $error("se0 kept after enable cleared");

  // engine routing and pull resistors
  engine_route_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    wr_hit |=> (peripheral_engine_sel == $past(cmd_wdata[BIT_ENG_SEL])) &&
      (host_engine_sel != peripheral_engine_sel))
    else $error("engine routing not updated");
  pulldown_dm_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    wr_hit |=> dm_pulldown_on == $past(cmd_wdata[BIT_DM_PD]))
    else $error("dm pull-down not updated");
  pulldown_dp_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    wr_hit |=> dp_pulldown_on == $past(cmd_wdata[BIT_DP_PD]))
    else $error("dp pull-down not updated");
  auto_pullup_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    rd_rise && ctrl_q[BIT_AUTO_PU] |=> ##1 dp_pullup_on)
    else $error("no pull-up after disconnect");
  local_pullup_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    !ctrl_q[BIT_AUTO_PU] && !auto_pu_q |=>
      dp_pullup_on == $past(ctrl_q[BIT_LOC_PU]))
    else $error("pull-up not following local bit");
  pullup_connect_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    ctrl_q[BIT_LOC_PU] |=> dp_pullup_on)
    else $error("pull-up off with local bit set");

  // reserved bits and read path
  reserved_zero_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    (cmd_rdata & ~CTRL_WMASK) == ZERO16)
    else $error("reserved bits read nonzero");
  reserved_store_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    (ctrl_q & ~CTRL_WMASK) == ZERO16)
    else $error("reserved bits stored");
  read_data_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    cmd_valid && (cmd_code == CMD_CTRL_RD) |=>
      cmd_rdata == ($past(ctrl_q) & CTRL_WMASK))
    else $error("read data differs from control word");
endmodule
`default_nettype wire

// ==== tb/otg_peer_model.sv ====
// Purpose: otg peer that makes line events at the port
// Assumes: events are asynchronous to mclk
// Notes:   lines rest low between events
`default_nettype none
module otg_peer_model
(
  output logic conn_line,
  output logic disc_line,
  output logic vbus_line,
  output logic data_line
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] ev_q = 3'h0;
  assign {data_line, vbus_line, disc_line} = ev_q;
  initial conn_line = 1'b0;
  task automatic set_conn(input logic v);
    conn_line = v;
  endtask
  // wider than two mclk periods so the synchroniser cannot miss it
  task automatic pulse(input int sel);
    ev_q[sel] = 1'b1;
    #130 ev_q[sel] = 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
// Purpose: self-checking bench for the otg port control block
// Assumes: control word reached by read and write command codes
// Notes:   read data is checked against a queue of expected words
`default_nettype none
module tb_top;
  import otg_ctrl_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic cmd_valid = 1'b0;
  logic [7:0] cmd_code = 8'h00;
  logic [15:0] cmd_wdata = 16'h0000;
  logic [15:0] cmd_rdata;
  logic clr = 1'b0;
  logic rd_seen = 1'b0;
  logic conn, disc, vbus, dpul, flag, se0, hsel, psel, dmpd, dppd, pu;
  logic [15:0] exp_q[$];
  int error_cnt = 0;
  int check_count = 0;
  always #20 mclk = ~mclk;
  otg_peer_model otg_peer_model_i (.conn_line(conn), .disc_line(disc),
    .vbus_line(vbus), .data_line(dpul));
  otg_port_control otg_port_control_i (.mclk(mclk), .reset_n(reset_n),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
    .cmd_rdata(cmd_rdata), .remote_connect_pin(conn),
    .remote_disconnect_pin(disc), .vbus_pulse_pin(vbus),
    .data_pulse_pin(dpul), .srp_flag_clear(clr),
    .srp_detected_flag(flag), .host_se0_reset(se0),
    .host_engine_sel(hsel), .peripheral_engine_sel(psel),
    .dm_pulldown_on(dmpd), .dp_pulldown_on(dppd), .dp_pullup_on(pu));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    if (error_cnt == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic cmd(input logic [7:0] code, input logic [15:0] d);
    @(negedge mclk);
    cmd_valid = 1'b1;
    cmd_code = code;
    cmd_wdata = d;
    @(negedge mclk);
    cmd_valid = 1'b0;
  endtask
  task automatic rd(input logic [15:0] exp);
    exp_q.push_back(exp);
    cmd(CMD_CTRL_RD, 16'h0000);
  endtask
  // order: se0, periph, host, dm pd, dp pd, dp pull-up, srp flag
  task automatic ochk(input logic [6:0] exp);
    @(negedge mclk);
    chk({9'h0, se0, psel, hsel, dmpd, dppd, pu, flag}, {9'h0, exp});
  endtask
  always @(posedge mclk)
    rd_seen <= cmd_valid && cmd_code == CMD_CTRL_RD;
  always @(negedge mclk)
    if (rd_seen)
      chk(cmd_rdata, exp_q.pop_front());
  initial
  begin
    #400000;
    error_cnt++;
    summarize();
  end
  initial
  begin
    logic [15:0] w;
    int k;
    void'($urandom(85));
    repeat (4) @(negedge mclk);
    reset_n = 1'b1;
    rd(CTRL_RESET);
    ochk(7'b0101100);
    // no line events here, so the pull-up must track the local bit only
    for (k = 0; k < 8; k++)
    begin
      w = 16'($urandom);
      cmd(CMD_CTRL_WR, w);
      rd(w & CTRL_WMASK);
      ochk({1'b0, w[8], ~w[8], w[7], w[6], w[4], 1'b0});
    end
    cmd(CMD_CTRL_WR, 16'h00c0);
    repeat (1250) @(negedge mclk);
    cmd(CMD_CTRL_WR, 16'h08c0);
    otg_peer_model_i.set_conn(1'b1);
    repeat (5) @(negedge mclk);
    ochk(7'b1011100);
    otg_peer_model_i.set_conn(1'b0);
    repeat (5) @(negedge mclk);
    cmd(CMD_CTRL_WR, 16'h00c0);
    otg_peer_model_i.set_conn(1'b1);
    repeat (5) @(negedge mclk);
    ochk(7'b0011100);
    otg_peer_model_i.set_conn(1'b0);
    // every enable, method and line combination
    for (k = 0; k < 8; k++)
    begin
      cmd(CMD_CTRL_WR, {5'h00, k[1], k[0], 9'h0c0});
      otg_peer_model_i.pulse(k[2] + 1);
      repeat (5) @(negedge mclk);
      ochk({6'b001110, k[1] & (k[0] == k[2])});
      clr = 1'b1;
      @(negedge mclk);
      clr = 1'b0;
    end
    cmd(CMD_CTRL_WR, 16'h00e0);
    ochk(7'b0011100);
    otg_peer_model_i.pulse(0);
    repeat (5) @(negedge mclk);
    ochk(7'b0011110);
    cmd(CMD_CTRL_WR, 16'h00f0);
    cmd(CMD_CTRL_WR, 16'h00d0);
    ochk(7'b0011110);
    cmd(CMD_CTRL_WR, 16'h00c0);
    ochk(7'b0011100);
    // unknown code: read data clears, control word untouched
    rd(16'h00c0);
    cmd(8'h67, 16'hffff);
    chk(cmd_rdata, ZERO16);
    ochk(7'b0011100);
    // mid-run reset must restore the reset word over a busy one
    cmd(CMD_CTRL_WR, 16'h0e30);
    ochk(7'b0010010);
    reset_n = 1'b0;
    repeat (2) @(negedge mclk);
    reset_n = 1'b1;
    rd(CTRL_RESET);
    ochk(7'b0101100);
    summarize();
  end
endmodule
`default_nettype wire
